// [rtl/vpqfa_pkg.sv]
`default_nettype none
package vpqfa_pkg;
  // ****************************************
  // register numbers and selects
  // ****************************************
  localparam logic [4:0] FAULT_ADDR_REG = 5'h08;
  localparam logic [4:0] ENTRY_HIGH_REG = 5'h0a;
  localparam logic [4:0] COUNTER_CTL_REG = 5'h19;
  localparam logic [4:0] THIRD_CONFIG_REG = 5'h10;
  localparam logic [2:0] THIRD_CONFIG_SEL = 3'h3;
  localparam int NUM_COUNTERS = 4;
  // ****************************************
  // field layout
  // ****************************************
  localparam int EVCTX_HI = 24;
  localparam int EVCTX_LO = 23;
  localparam int QUAL_EXL_BIT = 0;
  localparam int QUAL_K_BIT = 1;
  localparam int QUAL_S_BIT = 2;
  localparam int QUAL_U_BIT = 3;
  localparam int CAP_LPA_BIT = 7;
  localparam int UPN_HI = 58;
  localparam int UPN_LO = 32;
  localparam int UPN_W = UPN_HI - UPN_LO + 1;
  localparam logic [1:0] EVCTX_RESET = 2'h0;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTL_KEEP_MASK = 32'h0000_001f;
  // ****************************************
  // event context encodings
  // ****************************************
  localparam logic [1:0] EVCTX_ROOT = 2'h0;
  localparam logic [1:0] EVCTX_ROOT_INTV = 2'h1;
  localparam logic [1:0] EVCTX_GUEST = 2'h2;
  localparam logic [1:0] EVCTX_GUEST_INTV = 2'h3;
  typedef enum logic [1:0] {
    VPQFA_CTX_ROOT,
    VPQFA_CTX_INTV,
    VPQFA_CTX_GUEST
  } vpqfa_ctx_type;
endpackage
`default_nettype wire

// [rtl/vpqfa_counter_gate.sv]
`default_nettype none
module vpqfa_counter_gate (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wr,
  input wire logic root_mode,
  input wire logic [31:0] wdata,
  input wire vpqfa_pkg::vpqfa_ctx_type ctx,
  input wire logic user_mode,
  input wire logic super_mode,
  input wire logic kernel_mode,
  input wire logic exl_root,
  input wire logic event_in,
  output logic [31:0] ctl,
  output logic count_en
);
  logic [1:0] sel;
  logic qual_ok;
  logic ctx_ok;
  assign sel = ctl[vpqfa_pkg::EVCTX_HI:vpqfa_pkg::EVCTX_LO];
  assign qual_ok = (ctx == vpqfa_pkg::VPQFA_CTX_INTV) ?
    ctl[vpqfa_pkg::QUAL_EXL_BIT] :
    ((user_mode & ctl[vpqfa_pkg::QUAL_U_BIT]) |
     (super_mode & ctl[vpqfa_pkg::QUAL_S_BIT]) |
     (kernel_mode & ~exl_root & ctl[vpqfa_pkg::QUAL_K_BIT]) |
     (exl_root & ctl[vpqfa_pkg::QUAL_EXL_BIT]));
  assign ctx_ok =
    (sel == vpqfa_pkg::EVCTX_ROOT) ? (ctx == vpqfa_pkg::VPQFA_CTX_ROOT) :
    (sel == vpqfa_pkg::EVCTX_ROOT_INTV) ?
      (ctx == vpqfa_pkg::VPQFA_CTX_INTV) :
    (sel == vpqfa_pkg::EVCTX_GUEST) ? (ctx == vpqfa_pkg::VPQFA_CTX_GUEST) :
    (ctx != vpqfa_pkg::VPQFA_CTX_ROOT);
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctl <= vpqfa_pkg::CTL_RESET;
      count_en <= 1'b0;
    end else begin
      if (wr) begin
        ctl <= wdata & vpqfa_pkg::CTL_KEEP_MASK;
        if (root_mode) begin
          ctl[vpqfa_pkg::EVCTX_HI:vpqfa_pkg::EVCTX_LO] <=
            wdata[vpqfa_pkg::EVCTX_HI:vpqfa_pkg::EVCTX_LO];
        end else begin
          // guest write must not wipe the root setting
          ctl[vpqfa_pkg::EVCTX_HI:vpqfa_pkg::EVCTX_LO] <=
            ctl[vpqfa_pkg::EVCTX_HI:vpqfa_pkg::EVCTX_LO];
        end
      end
      count_en <= event_in & ctx_ok & qual_ok;
    end
  end
endmodule
`default_nettype wire

// [rtl/vpqfa_regs.sv]
`default_nettype none
module vpqfa_regs (
  input wire logic mclk,
  input wire logic rst,
  input wire logic guest_running_flag,
  input wire logic exception_level_flag,
  input wire logic error_level_flag,
  input wire logic debug_state_flag,
  input wire logic user_mode,
  input wire logic super_mode,
  input wire logic kernel_mode,
  input wire logic [vpqfa_pkg::NUM_COUNTERS-1:0] counter_event,
  input wire logic load_address_error,
  input wire logic store_address_error,
  input wire logic translation_refill,
  input wire logic load_translation_invalid,
  input wire logic store_translation_invalid,
  input wire logic translation_modified,
  input wire logic cache_error,
  input wire logic bus_error,
  input wire logic watch_exception,
  input wire logic [63:0] fault_va,
  input wire logic translation_read,
  input wire logic [63:0] translation_read_hi,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic high_half,
  input wire logic guest_access,
  input wire logic [4:0] reg_num,
  input wire logic [2:0] reg_sel,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic [vpqfa_pkg::NUM_COUNTERS-1:0] counter_inc,
  output logic [31:0] faulting_virtual_address_hi,
  output logic [31:0] faulting_virtual_address_lo,
  output logic [vpqfa_pkg::UPN_W-1:0] upper_page_number
);
  // ****************************************
  // context classification
  // ****************************************
  logic root_flags;
  vpqfa_pkg::vpqfa_ctx_type ctx;
  logic root_mode;
  assign root_flags = exception_level_flag | error_level_flag |
    debug_state_flag;
  always_comb begin
    if (!guest_running_flag) begin
      ctx = vpqfa_pkg::VPQFA_CTX_ROOT;
    end else if (root_flags) begin
      ctx = vpqfa_pkg::VPQFA_CTX_INTV;
    end else begin
      ctx = vpqfa_pkg::VPQFA_CTX_GUEST;
    end
  end
  assign root_mode = !guest_access && (ctx != vpqfa_pkg::VPQFA_CTX_GUEST);
  // ****************************************
  // counter controls
  // ****************************************
  logic [31:0] ctl [vpqfa_pkg::NUM_COUNTERS];
  logic [31:0] ctl_rd [vpqfa_pkg::NUM_COUNTERS];
  logic ctl_hit;
  assign ctl_hit = (reg_num == vpqfa_pkg::COUNTER_CTL_REG) && !high_half &&
    ({1'b0, reg_sel[2:1]} < 3'(vpqfa_pkg::NUM_COUNTERS));
  genvar gi;
  generate
    for (gi = 0; gi < vpqfa_pkg::NUM_COUNTERS; gi++) begin : g_ctr
      vpqfa_counter_gate u_gate (
        .mclk(mclk),
        .rst(rst),
        .wr(reg_wr && ctl_hit && (reg_sel[2:1] == 2'(gi)) && !reg_sel[0]),
        .root_mode(root_mode),
        .wdata(reg_wdata),
        .ctx(ctx),
        .user_mode(user_mode),
        .super_mode(super_mode),
        .kernel_mode(kernel_mode),
        .exl_root(exception_level_flag),
        .event_in(counter_event[gi]),
        .ctl(ctl[gi]),
        .count_en(counter_inc[gi])
      );
      assign ctl_rd[gi] = root_mode ? ctl[gi] :
        (ctl[gi] & ~(32'h0000_0003 << vpqfa_pkg::EVCTX_LO));
    end
  endgenerate
  // ****************************************
  // faulting address
  // ****************************************
  logic fault_capture;
  assign fault_capture = (load_address_error | store_address_error |
    translation_refill | load_translation_invalid |
    store_translation_invalid | translation_modified) &
    ~(cache_error | bus_error | watch_exception);
  always_ff @(posedge mclk) begin
    if (fault_capture) begin
      faulting_virtual_address_hi <= fault_va[63:32];
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      faulting_virtual_address_lo <= 32'h0000_0000;
    end else if (fault_capture) begin
      faulting_virtual_address_lo <= fault_va[31:0];
    end
  end
  // ****************************************
  // entry high extension
  // ****************************************
  logic ehi_hit;
  assign ehi_hit = (reg_num == vpqfa_pkg::ENTRY_HIGH_REG) &&
    (reg_sel == 3'h0) && high_half && !guest_access;
  always_ff @(posedge mclk) begin
    if (fault_capture) begin
      upper_page_number <= fault_va[vpqfa_pkg::UPN_HI:vpqfa_pkg::UPN_LO];
    end else if (translation_read) begin
      upper_page_number <=
        translation_read_hi[vpqfa_pkg::UPN_HI:vpqfa_pkg::UPN_LO];
    end else if (reg_wr && ehi_hit) begin
      upper_page_number <= reg_wdata[vpqfa_pkg::UPN_W-1:0];
    end
  end
  // ****************************************
  // read mux
  // ****************************************
  logic [31:0] next_rdata;
  logic [31:0] cap_word;
  assign cap_word = 32'h0000_0001 << vpqfa_pkg::CAP_LPA_BIT;
  // high half only by high moves
  assign next_rdata =
    (reg_num == vpqfa_pkg::COUNTER_CTL_REG && ctl_hit && !reg_sel[0]) ?
      ctl_rd[reg_sel[2:1]] :
    (reg_num == vpqfa_pkg::FAULT_ADDR_REG && reg_sel == 3'h0) ?
      (high_half ? faulting_virtual_address_hi :
        faulting_virtual_address_lo) :
    ehi_hit ? {{(32 - vpqfa_pkg::UPN_W){1'b0}}, upper_page_number} :
    (reg_num == vpqfa_pkg::THIRD_CONFIG_REG && !high_half &&
     reg_sel == vpqfa_pkg::THIRD_CONFIG_SEL && !guest_access) ?
      cap_word : 32'h0000_0000;
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end
  // ****************************************
  // checks
  // ****************************************
  property p_evctx_guest_ro;
    @(posedge mclk) disable iff (rst)
      (reg_wr && ctl_hit && !root_mode && reg_sel == 3'h0) |=>
      $stable(ctl[0][vpqfa_pkg::EVCTX_HI:vpqfa_pkg::EVCTX_LO]);
  endproperty
  a_evctx_guest_ro: assert property (p_evctx_guest_ro)
    else $error("context field changed outside root");
  property p_root_count;
    @(posedge mclk) disable iff (rst)
      (counter_event[0] && guest_running_flag &&
       ctl[0][vpqfa_pkg::EVCTX_HI:vpqfa_pkg::EVCTX_LO] == 2'h0)
      |=> !counter_inc[0];
  endproperty
  a_root_count: assert property (p_root_count)
    else $error("root setting counted in guest");
  property p_guest_count;
    @(posedge mclk) disable iff (rst)
      (counter_event[0] && ctl[0][vpqfa_pkg::EVCTX_HI] &&
       !guest_running_flag)
      |=> !counter_inc[0];
  endproperty
  a_guest_count: assert property (p_guest_count)
    else $error("guest setting counted in root");
  property p_class_root;
    @(posedge mclk) disable iff (rst)
      !guest_running_flag |-> ctx == vpqfa_pkg::VPQFA_CTX_ROOT;
  endproperty
  a_class_root: assert property (p_class_root)
    else $error("root event misclassified");
  property p_class_intv;
    @(posedge mclk) disable iff (rst)
      (guest_running_flag && root_flags) |->
      ctx == vpqfa_pkg::VPQFA_CTX_INTV;
  endproperty
  a_class_intv: assert property (p_class_intv)
    else $error("intervention misclassified");
  property p_class_guest;
    @(posedge mclk) disable iff (rst)
      (ctx == vpqfa_pkg::VPQFA_CTX_GUEST) |->
      (guest_running_flag && !root_flags);
  endproperty
  a_class_guest: assert property (p_class_guest)
    else $error("guest misclassified");
  property p_no_event;
    @(posedge mclk) disable iff (rst)
      !counter_event[1] |=> !counter_inc[1];
  endproperty
  a_no_event: assert property (p_no_event)
    else $error("count without event");
  property p_fault_cap;
    @(posedge mclk) disable iff (rst)
      fault_capture |=> faulting_virtual_address_lo == $past(fault_va[31:0]);
  endproperty
  a_fault_cap: assert property (p_fault_cap)
    else $error("fault address not captured");
  property p_fault_hold;
    @(posedge mclk) disable iff (rst)
      (!fault_capture && (bus_error || cache_error || watch_exception))
      |=> $stable(faulting_virtual_address_lo);
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("fault address changed by excluded fault");
endmodule
`default_nettype wire

// [sim/vpqfa_core_model.sv]
`default_nettype none
module vpqfa_core_model (
  input wire logic mclk,
  output logic guest_running_flag,
  output logic exception_level_flag,
  output logic error_level_flag,
  output logic debug_state_flag,
  output logic [8:0] fault_pulse,
  output logic [63:0] fault_va,
  output logic translation_read,
  output logic [63:0] translation_read_hi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {guest_running_flag, exception_level_flag} = 2'h0;
    {error_level_flag, debug_state_flag, translation_read} = 3'h0;
    fault_pulse = 9'h000;
    fault_va = 64'h0000_0000_0000_0000;
    translation_read_hi = 64'h0000_0000_0000_0000;
  end
  // ********************
  // core events
  // ********************
  // flags per context
  task automatic set_cls(input int c, input logic [1:0] r);
    @(negedge mclk);
    guest_running_flag = (c != 0);
    exception_level_flag = (c == 1) && (r == 2'h0);
    error_level_flag = (c == 1) && (r == 2'h1);
    debug_state_flag = (c == 1) && r[1];
  endtask
  task automatic fault(input int k, input logic [63:0] va);
    @(negedge mclk);
    fault_pulse = 9'h001 << k;
    fault_va = va;
    @(negedge mclk);
    fault_pulse = 9'h000;
    fault_va = ~va;
  endtask
  task automatic tr_read(input logic [63:0] va);
    @(negedge mclk);
    translation_read = 1'b1;
    translation_read_hi = va;
    @(negedge mclk);
    translation_read = 1'b0;
    translation_read_hi = ~va;
  endtask
endmodule
`default_nettype wire

// [sim/testbench.sv]
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, reg_wr, reg_rd, high_half, guest_access, translation_read;
  logic user_mode, super_mode, kernel_mode, guest_running_flag;
  logic exception_level_flag, error_level_flag, debug_state_flag;
  logic [4:0] reg_num;
  logic [2:0] reg_sel;
  logic [31:0] reg_wdata, reg_rdata, rd_val, d;
  logic [31:0] faulting_virtual_address_hi, faulting_virtual_address_lo;
  logic [3:0] counter_event, counter_inc, q;
  logic [1:0] ec;
  logic [8:0] fault_pulse;
  logic [63:0] fault_va, translation_read_hi, fv, va;
  logic [vpqfa_pkg::UPN_W-1:0] upper_page_number;
  int n_errors = 0, tests_run = 0, cycles = 0, i, k, c;
  integer seed;
  vpqfa_regs u_vpqfa_regs (
    .mclk, .rst, .guest_running_flag, .exception_level_flag,
    .error_level_flag, .debug_state_flag, .user_mode, .super_mode,
    .kernel_mode, .counter_event, .load_address_error(fault_pulse[0]),
    .store_address_error(fault_pulse[1]),
    .translation_refill(fault_pulse[2]),
    .load_translation_invalid(fault_pulse[3]),
    .store_translation_invalid(fault_pulse[4]),
    .translation_modified(fault_pulse[5]), .cache_error(fault_pulse[6]),
    .bus_error(fault_pulse[7]), .watch_exception(fault_pulse[8]),
    .fault_va, .translation_read, .translation_read_hi, .reg_wr, .reg_rd,
    .high_half, .guest_access, .reg_num, .reg_sel, .reg_wdata, .reg_rdata,
    .counter_inc, .faulting_virtual_address_hi,
    .faulting_virtual_address_lo, .upper_page_number
  );
  vpqfa_core_model u_core (
    .mclk, .guest_running_flag, .exception_level_flag, .error_level_flag,
    .debug_state_flag, .fault_pulse, .fault_va, .translation_read,
    .translation_read_hi
  );
  // ********************
  // clock, timeout, helpers
  // ********************
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // generous: the whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (n_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e,
      input logic [63:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [4:0] n,
      input logic [2:0] s, input logic h, input logic g,
      input logic [31:0] wd);
    @(negedge mclk);
    {reg_wr, reg_rd, reg_num, reg_sel} = {w, !w, n, s};
    {high_half, guest_access, reg_wdata} = {h, g, wd};
    @(negedge mclk);
    {reg_wr, reg_rd} = 2'h0;
    rd_val = reg_rdata;
  endtask
  function automatic logic exp_cnt(input logic [1:0] e, input int cl,
      input logic [3:0] qb);
    logic hit;
    hit = (cl == 0) ? (e == 2'h0) : (cl == 1) ? e[0] : e[1];
    if (cl == 1)
      return hit && qb[vpqfa_pkg::QUAL_EXL_BIT];
    return hit && qb[vpqfa_pkg::QUAL_K_BIT];
  endfunction
  // ********************
  // main sequence
  // ********************
  initial begin
    seed = 32'h3a9f_7505;
    {rst, reg_wr, reg_rd, high_half, guest_access} = 5'h10;
    {reg_num, reg_sel, reg_wdata, counter_event} = 44'h0;
    {user_mode, super_mode, kernel_mode} = 3'h1;
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    acc(1'b0, vpqfa_pkg::COUNTER_CTL_REG, 3'h0, 1'b0, 1'b0, 32'h0);
    chk("ctl_reset", 64'h0, rd_val);
    chk("fault_lo_reset", 64'h0, faulting_virtual_address_lo);
    acc(1'b0, vpqfa_pkg::THIRD_CONFIG_REG, vpqfa_pkg::THIRD_CONFIG_SEL,
      1'b0, 1'b0, 32'h0);
    chk("cap_bit", 64'h1, rd_val[vpqfa_pkg::CAP_LPA_BIT]);
    acc(1'b0, 5'h1f, 3'h0, 1'b0, 1'b0, 32'h0);
    chk("unmapped", 64'h0, rd_val);
    u_core.set_cls(0, 2'h0);
    d = $random(seed) | 32'h0180_0000;
    acc(1'b1, vpqfa_pkg::COUNTER_CTL_REG, 3'h0, 1'b0, 1'b0, d);
    acc(1'b0, vpqfa_pkg::COUNTER_CTL_REG, 3'h0, 1'b0, 1'b0, 32'h0);
    chk("ec_probe", d & 32'h0180_001f, rd_val);
    u_core.set_cls(2, 2'h0);
    acc(1'b1, vpqfa_pkg::COUNTER_CTL_REG, 3'h0, 1'b0, 1'b0, d ^ 32'h0180_0001);
    acc(1'b0, vpqfa_pkg::COUNTER_CTL_REG, 3'h0, 1'b0, 1'b0, 32'h0);
    chk("ec_guest", (d & 32'h0000_001f) ^ 32'h1, rd_val);
    u_core.set_cls(0, 2'h0);
    acc(1'b0, vpqfa_pkg::COUNTER_CTL_REG, 3'h0, 1'b0, 1'b0, 32'h0);
    chk("ec_kept", (d & 32'h0180_001f) ^ 32'h1, rd_val);
    for (i = 0; i < 36; i++) begin
      ec = 2'(i);
      c = (i / 4) % 3;
      q = 4'($random(seed));
      k = $random(seed) & 3;
      u_core.set_cls(0, 2'h0);
      acc(1'b1, vpqfa_pkg::COUNTER_CTL_REG, 3'(2 * k), 1'b0, 1'b0,
        {7'h00, ec, 19'h0_0000, q});
      u_core.set_cls(c, 2'($random(seed)));
      @(negedge mclk);
      counter_event = 4'hf;
      @(negedge mclk);
      counter_event = 4'h0;
      chk("count", exp_cnt(ec, c, q), counter_inc[k]);
    end
    d = $random(seed) | 32'hf800_0000;
    acc(1'b1, vpqfa_pkg::ENTRY_HIGH_REG, 3'h0, 1'b1, 1'b0, d);
    chk("upn_sw", d[26:0], upper_page_number);
    acc(1'b0, vpqfa_pkg::ENTRY_HIGH_REG, 3'h0, 1'b1, 1'b0, 32'h0);
    chk("eh_high", {5'h00, d[26:0]}, rd_val);
    acc(1'b1, vpqfa_pkg::ENTRY_HIGH_REG, 3'h0, 1'b1, 1'b1, ~d);
    chk("upn_guest_wr", d[26:0], upper_page_number);
    acc(1'b0, vpqfa_pkg::ENTRY_HIGH_REG, 3'h0, 1'b1, 1'b1, 32'h0);
    chk("eh_guest", 64'h0, rd_val);
    va = {$random(seed), $random(seed)};
    u_core.tr_read(va);
    chk("upn_hw", va[58:32], upper_page_number);
    fv = 64'h0;
    for (k = 0; k < 9; k++) begin
      va = {$random(seed), $random(seed)};
      u_core.fault(k, va);
      if (k < 6)
        fv = va;
      chk("fault_hi", fv[63:32], faulting_virtual_address_hi);
      chk("fault_lo", fv[31:0], faulting_virtual_address_lo);
    end
    acc(1'b1, vpqfa_pkg::FAULT_ADDR_REG, 3'h0, 1'b0, 1'b0, ~fv[31:0]);
    chk("fault_ro", fv[31:0], faulting_virtual_address_lo);
    acc(1'b0, vpqfa_pkg::FAULT_ADDR_REG, 3'h0, 1'b1, 1'b0, 32'h0);
    chk("fault_rd_hi", fv[63:32], rd_val);
    wrap_up();
  end
endmodule
`default_nettype wire
